// >>> pkg/id_tag_pkg.sv
// Constants and carrier types for the message identifier tag registers
package id_tag_pkg;
	localparam logic [7:0] ADDR_BYTE1 = 8'hBC;
	localparam logic [7:0] ADDR_BYTE2 = 8'hBD;
	localparam logic [7:0] ADDR_BYTE3 = 8'hBE;
	localparam logic [7:0] ADDR_BYTE4 = 8'hBF;
	localparam int         NUM_BYTES  = 4;
	// Byte 4 field positions
	localparam int         POS_ID_LO_MSB = 7;
	localparam int         POS_ID_LO_LSB = 3;
	localparam int         POS_RTR       = 2;
	localparam int         POS_RB1       = 1;
	localparam int         POS_RB0       = 0;
	// Byte 2 standard-format identifier field
	localparam int         POS_STD_ID_LSB = 5;
	// Power-up fill value; contents are undefined to software
	localparam logic [7:0] FILL_VALUE = 8'h00;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;

	typedef struct packed {
		logic [28:0] identifier_tag_bits;
		logic        remote_request_tag;
		logic        frame_reserved1_tag;
		logic        frame_reserved0_tag;
	} tag_view_s;
endpackage

// >>> logic/id_tag_byte_store.sv
// Four byte tag storage with one write port, one addressed read port and a whole-word output of all four bytes
`timescale 1ns/1ps
module id_tag_byte_store
(
	input  wire logic       clk_in,
	input  wire logic       en_in,
	input  wire logic       we_in,
	input  wire logic [1:0] wsel_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic [1:0] rsel_in,
	output logic      [7:0] rdata_out,
	output logic [31:0]     all_out
);
	// No reset: contents undefined until software writes them
	logic [7:0] mem_q [0:3];
	logic [7:0] wval_d;

	always_comb
	begin
		wval_d = mem_q[wsel_in];
		if (we_in)
		begin
			wval_d = wdata_in;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (en_in)
		begin
			mem_q[wsel_in] <= wval_d;
		end
	end

	assign rdata_out = mem_q[rsel_in];
	assign all_out   = {mem_q[0], mem_q[1], mem_q[2], mem_q[3]};
endmodule

// >>> logic/msg_id_tag_regs.sv
// Identifier tag register bank of one CAN message object
`timescale 1ns/1ps
//
// Contract
// - Extended: identifier 28..21 in byte 1 bits 7..0, MSB at bit 7.
// - Extended: identifier 20..13 in byte 2 bits 7..0, descending.
// - Extended: identifier 12..5 in byte 3 bits 7..0.
// - Extended: identifier 4..0 in byte 4 bits 7..3.
// - Remote-request tag in byte 4 bit 2, both formats.
// - Extended: reserved bit 1 tag in byte 4 bit 1.
// - Reserved bit 0 tag in byte 4 bit 0, both formats.
// - Standard: byte 3 wholly reserved, no identifier content.
// - Standard: byte 4 bits 7..3 and bit 1 reserved.
// - Reserved bits may read any value; tests ignore them.
// - No defined value after reset; undefined until written.
// - Standard: identifier 10..3 in byte 1 bits 7..0.
// - Standard: identifier 2..0 in byte 2 bits 7..5; 4..0 reserved.
module msg_id_tag_regs
(
	input  wire logic                 core_clk_in,
	input  wire logic                 nrst_in,
	input  wire logic                 clk_en_in,
	input  wire logic                 extended_fmt_in,
	input  wire logic                 sfr_wr_in,
	input  wire logic                 sfr_rd_in,
	input  wire logic [7:0]           sfr_addr_in,
	input  wire logic [7:0]           sfr_wdata_in,
	output logic      [7:0]           sfr_rdata_out,
	output logic                      sfr_hit_out,
	output id_tag_pkg::tag_view_s     tag_view_out
);
	// ---------------------------------------------
	// Reset release
	// ---------------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// ---------------------------------------------
	// Address decode
	// ---------------------------------------------
	function automatic logic in_bank(input logic [7:0] a);
		in_bank = (a >= id_tag_pkg::ADDR_BYTE1) && (a <= id_tag_pkg::ADDR_BYTE4);
	endfunction

	function automatic logic [1:0] bank_index(input logic [7:0] a);
		logic [7:0] d;
		d = a - id_tag_pkg::ADDR_BYTE1;
		bank_index = d[1:0];
	endfunction

	id_tag_pkg::sfr_req_s req;
	assign req = '{wr: sfr_wr_in, rd: sfr_rd_in, addr: sfr_addr_in, wdata: sfr_wdata_in};

	logic       wr_hit;
	logic       rd_hit;
	logic [7:0] raw_rdata;
	logic [31:0] all_bytes;

	// host keeps reserved bits zero
	// Written bytes are stored as given; no masking so reads echo writes
	assign wr_hit = rst_sync_q && req.wr && in_bank(req.addr);
	assign rd_hit = req.rd && in_bank(req.addr);

	id_tag_byte_store u_store
	(
		.clk_in    (core_clk_in),
		.en_in     (clk_en_in),
		.we_in     (wr_hit),
		.wsel_in   (bank_index(req.addr)),
		.wdata_in  (req.wdata),
		.rsel_in   (bank_index(req.addr)),
		.rdata_out (raw_rdata),
		.all_out   (all_bytes)
	);

	// ---------------------------------------------
	// Read data register
	// ---------------------------------------------
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       hit_q;
	logic       hit_d;

	always_comb
	begin
		rdata_d = rdata_q;
		hit_d   = 1'b0;
		if (rd_hit)
		begin
			rdata_d = raw_rdata;
			hit_d   = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			rdata_q <= 8'h00;
			hit_q   <= 1'b0;
		end
		else if (clk_en_in)
		begin
			rdata_q <= rdata_d;
			hit_q   <= hit_d;
		end
	end

	assign sfr_rdata_out = rdata_q;
	assign sfr_hit_out   = hit_q;

	// ---------------------------------------------
	// Format-dependent view for compare logic
	// ---------------------------------------------
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [7:0] b4;
	assign b1 = all_bytes[31:24];
	assign b2 = all_bytes[23:16];
	assign b3 = all_bytes[15:8];
	assign b4 = all_bytes[7:0];

	always_comb
	begin
		tag_view_out = '0;
		tag_view_out.remote_request_tag  = b4[id_tag_pkg::POS_RTR];
		tag_view_out.frame_reserved0_tag = b4[id_tag_pkg::POS_RB0];
		if (extended_fmt_in)
		begin
			tag_view_out.identifier_tag_bits = {b1, b2, b3,
				b4[id_tag_pkg::POS_ID_LO_MSB:id_tag_pkg::POS_ID_LO_LSB]};
			tag_view_out.frame_reserved1_tag = b4[id_tag_pkg::POS_RB1];
		end
		else
		begin
			tag_view_out.identifier_tag_bits = {18'h00000, b1,
				b2[7:id_tag_pkg::POS_STD_ID_LSB]};
		end
	end

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_sync_q);

	// Checked against the written byte; storage reads X until written
	sequence wr_byte1_s;
		clk_en_in && wr_hit && sfr_addr_in == id_tag_pkg::ADDR_BYTE1;
	endsequence

	sequence wr_byte2_s;
		clk_en_in && wr_hit && sfr_addr_in == id_tag_pkg::ADDR_BYTE2;
	endsequence

	sequence wr_byte3_s;
		clk_en_in && wr_hit && sfr_addr_in == id_tag_pkg::ADDR_BYTE3;
	endsequence

	sequence wr_byte4_s;
		clk_en_in && wr_hit && sfr_addr_in == id_tag_pkg::ADDR_BYTE4;
	endsequence

	rd_hit_pulse_a: assert property (clk_en_in && rd_hit |=> sfr_hit_out)
		else $error("read hit not flagged");
	ext_id_hi_a: assert property (wr_byte1_s ##1 extended_fmt_in
		|-> tag_view_out.identifier_tag_bits[28:21] == $past(sfr_wdata_in))
		else $error("extended id high byte wrong");
	std_id_hi_a: assert property (wr_byte1_s ##1 !extended_fmt_in
		|-> tag_view_out.identifier_tag_bits[10:3] == $past(sfr_wdata_in))
		else $error("standard id high byte wrong");
	ext_id_mid_a: assert property (wr_byte2_s ##1 extended_fmt_in
		|-> tag_view_out.identifier_tag_bits[20:13] == $past(sfr_wdata_in))
		else $error("extended id byte 2 wrong");
	ext_id_low_a: assert property (wr_byte3_s ##1 extended_fmt_in
		|-> tag_view_out.identifier_tag_bits[12:5] == $past(sfr_wdata_in))
		else $error("extended id byte 3 wrong");
	ext_id_tail_a: assert property (wr_byte4_s ##1 extended_fmt_in
		|-> tag_view_out.identifier_tag_bits[4:0] == $past(sfr_wdata_in[7:3]))
		else $error("extended id tail wrong");
	rtr_tag_a: assert property (wr_byte4_s
		|=> tag_view_out.remote_request_tag == $past(sfr_wdata_in[2]))
		else $error("remote tag wrong");
	rb1_tag_a: assert property (wr_byte4_s ##1 extended_fmt_in
		|-> tag_view_out.frame_reserved1_tag == $past(sfr_wdata_in[1]))
		else $error("reserved1 tag wrong");
	rb0_tag_a: assert property (wr_byte4_s
		|=> tag_view_out.frame_reserved0_tag == $past(sfr_wdata_in[0]))
		else $error("reserved0 tag wrong");
	std_upper_a: assert property (!extended_fmt_in
		|-> tag_view_out.identifier_tag_bits[28:11] == 18'h00000
		&& !tag_view_out.frame_reserved1_tag)
		else $error("standard view has reserved content");
	std_low_a: assert property (wr_byte2_s ##1 !extended_fmt_in
		|-> tag_view_out.identifier_tag_bits[2:0] == $past(sfr_wdata_in[7:5]))
		else $error("standard id low bits wrong");
endmodule

// >>> bench/tb_top.sv
// Self-checking testbench for the identifier tag register bank
`timescale 1ns/1ps
module tb_top;
	logic                  core_clk_in;
	logic                  nrst_in;
	logic                  clk_en_in;
	logic                  extended_fmt_in;
	logic                  sfr_wr_in;
	logic                  sfr_rd_in;
	logic [7:0]            sfr_addr_in;
	logic [7:0]            sfr_wdata_in;
	logic [7:0]            sfr_rdata_out;
	logic                  sfr_hit_out;
	id_tag_pkg::tag_view_s tag_view_out;
	int                    err_count;
	int                    n_checks;

	msg_id_tag_regs dut
	(
		.core_clk_in     (core_clk_in),
		.nrst_in         (nrst_in),
		.clk_en_in       (clk_en_in),
		.extended_fmt_in (extended_fmt_in),
		.sfr_wr_in       (sfr_wr_in),
		.sfr_rd_in       (sfr_rd_in),
		.sfr_addr_in     (sfr_addr_in),
		.sfr_wdata_in    (sfr_wdata_in),
		.sfr_rdata_out   (sfr_rdata_out),
		.sfr_hit_out     (sfr_hit_out),
		.tag_view_out    (tag_view_out)
	);

	// ----------------------------------------
	// Clock, checks and closing report
	// ----------------------------------------
	initial
	begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// Bus cycles
	// ----------------------------------------
	// Strobe is left high so writes run back to back; idle drops it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_wr_in    = 1'b1;
		sfr_addr_in  = a;
		sfr_wdata_in = d;
		@(negedge core_clk_in);
	endtask

	task automatic idle();
		sfr_wr_in = 1'b0;
		sfr_rd_in = 1'b0;
		@(negedge core_clk_in);
	endtask

	task automatic rd(input logic [7:0] a, input logic hit, input logic [7:0] d);
		sfr_rd_in   = 1'b1;
		sfr_addr_in = a;
		@(negedge core_clk_in);
		check("read hit", 32'(sfr_hit_out), 32'(hit));
		check("read data", 32'(sfr_rdata_out), 32'(d));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic ext_layout();
		extended_fmt_in = 1'b1;
		wr(id_tag_pkg::ADDR_BYTE1, 8'hA5);
		wr(id_tag_pkg::ADDR_BYTE2, 8'h3C);
		wr(id_tag_pkg::ADDR_BYTE3, 8'h96);
		wr(id_tag_pkg::ADDR_BYTE4, 8'h5A);
		idle();
		check("id 28:21", 32'(tag_view_out.identifier_tag_bits[28:21]), 32'hA5);
		check("id 20:13", 32'(tag_view_out.identifier_tag_bits[20:13]), 32'h3C);
		check("id 12:5", 32'(tag_view_out.identifier_tag_bits[12:5]), 32'h96);
		check("id 4:0", 32'(tag_view_out.identifier_tag_bits[4:0]), 32'h0B);
		check("rtr ext", 32'(tag_view_out.remote_request_tag), 32'h0);
		check("rb1 ext", 32'(tag_view_out.frame_reserved1_tag), 32'h1);
		check("rb0 ext", 32'(tag_view_out.frame_reserved0_tag), 32'h0);
		rd(id_tag_pkg::ADDR_BYTE1, 1'b1, 8'hA5);
		rd(id_tag_pkg::ADDR_BYTE2, 1'b1, 8'h3C);
		rd(id_tag_pkg::ADDR_BYTE3, 1'b1, 8'h96);
		rd(id_tag_pkg::ADDR_BYTE4, 1'b1, 8'h5A);
		idle();
	endtask

	task automatic std_layout();
		extended_fmt_in = 1'b0;
		wr(id_tag_pkg::ADDR_BYTE1, 8'hC3);
		wr(id_tag_pkg::ADDR_BYTE2, 8'hA0);
		wr(id_tag_pkg::ADDR_BYTE3, 8'h00);
		wr(id_tag_pkg::ADDR_BYTE4, 8'h05);
		idle();
		check("std id", 32'(tag_view_out.identifier_tag_bits[10:0]), 32'h61D);
		check("std upper", 32'(tag_view_out.identifier_tag_bits[28:11]), 32'h0);
		check("rtr std", 32'(tag_view_out.remote_request_tag), 32'h1);
		check("rb0 std", 32'(tag_view_out.frame_reserved0_tag), 32'h1);
		rd(id_tag_pkg::ADDR_BYTE1, 1'b1, 8'hC3);
		idle();
	endtask

	task automatic refused();
		rd(8'hBB, 1'b0, 8'hC3);
		rd(8'hC0, 1'b0, 8'hC3);
		idle();
		clk_en_in = 1'b0;
		wr(id_tag_pkg::ADDR_BYTE1, 8'h11);
		idle();
		clk_en_in = 1'b1;
		// Read in the cycle of a write returns the old byte
		sfr_rd_in = 1'b1;
		wr(id_tag_pkg::ADDR_BYTE1, 8'h3E);
		check("rdata during write", 32'(sfr_rdata_out), 32'hC3);
		idle();
		rd(id_tag_pkg::ADDR_BYTE1, 1'b1, 8'h3E);
		idle();
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		err_count = 0;
		n_checks = 0;
		nrst_in = 1'b0;
		clk_en_in = 1'b1;
		extended_fmt_in = 1'b1;
		sfr_wr_in = 1'b0;
		sfr_rd_in = 1'b0;
		sfr_addr_in = 8'h00;
		sfr_wdata_in = 8'h00;
		repeat (16) @(negedge core_clk_in);
		check("hit in reset", 32'(sfr_hit_out), 32'h0);
		check("rdata in reset", 32'(sfr_rdata_out), 32'h0);
		nrst_in = 1'b1;
		// Synchronised release needs a few edges before writes land
		repeat (4) @(negedge core_clk_in);
		ext_layout();
		std_layout();
		refused();
		end_sim();
	end

	initial
	begin
		repeat (2000) @(posedge core_clk_in);
		err_count++;
		$display("unexpected run length: expected under 2000 cycles, seen 2000");
		end_sim();
	end
endmodule
